// ==== shared/remote_io_pkg.sv ====
/*
 * Shared definitions for the remote parallel I/O mapper: sizes, channel and
 * control encodings, configuration and status carriers, timing constants.
 * Assumes a single 50 MHz system clock with a synchronous active-high reset.
 */
package remote_io_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int N_IN        = 24;
	localparam int N_OUT       = 24;
	localparam int SEL_W       = 5;
	localparam int PRESET_W    = 3;
	localparam int ALARM_W     = 16;
	localparam int OUT_IDX_W   = 4;
	localparam int STEP_W      = 16;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ          = 50_000_000;
	localparam int REPEAT_MS       = 500;
	localparam int REPEAT_CYCLES   = CLK_HZ / 1000 * REPEAT_MS;
	localparam int REPEAT_CNT_W    = 25;
	localparam int POWER_STEP_WATT = 100;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		CH_NONE,
		CH_RF,
		CH_RESET,
		CH_PWR_INC,
		CH_PWR_DEC,
		CH_EXCITER,
		CH_AUTO_CO,
		CH_WATCHDOG,
		CH_PRESET
	} in_chan_e;

	typedef enum logic [3:0] {
		CT_FALL_ON,
		CT_RISE_ON,
		CT_FALL_OFF,
		CT_RISE_OFF,
		CT_FALL_TOG,
		CT_RISE_TOG,
		CT_RISE_ON_FALL_OFF,
		CT_FALL_ON_RISE_OFF,
		CT_ACTIVE_HIGH,
		CT_ACTIVE_LOW
	} in_ctrl_e;

	typedef enum logic [2:0] {
		OS_NONE,
		OS_RF_ON,
		OS_LOCAL,
		OS_EXCITER_A,
		OS_AUTO_CO,
		OS_PRESET,
		OS_MOD_LOSS,
		OS_ALARM
	} out_src_e;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		in_chan_e              chan;
		in_ctrl_e              ctrl;
		logic [PRESET_W-1:0]   preset;
	} in_cfg_s;

	typedef struct packed {
		out_src_e              src;
		logic [OUT_IDX_W-1:0]  idx;
		logic                  low_true;
	} out_cfg_s;

	typedef struct packed {
		logic                  rf_on;
		logic                  remote;
		logic                  exciter_b;
		logic                  auto_co;
		logic                  mod_loss;
		logic [PRESET_W-1:0]   preset;
		logic [ALARM_W-1:0]    alarm;
	} status_s;

	typedef struct packed {
		logic                  act;
		logic                  deact;
		logic                  tog;
	} in_event_s;

	localparam in_cfg_s  IN_CFG_RST  = '{chan: CH_NONE, ctrl: CT_FALL_ON, preset: '0};
	localparam out_cfg_s OUT_CFG_RST = '{src: OS_NONE, idx: '0, low_true: 1'b0};

endpackage : remote_io_pkg

// ==== design/input_interpreter.sv ====
/*
 * One remote input: synchroniser, edge and level detection, toggle memory
 * and hold-repeat timer. Produces one-cycle activate/deactivate events.
 * Assumes the pin is asynchronous to clk and clear pulses on each commit.
 */
`timescale 1ns/1ps
`default_nettype none

module input_interpreter #(
	parameter int REPEAT_CYCLES = remote_io_pkg::REPEAT_CYCLES,
	parameter int CNT_W         = remote_io_pkg::REPEAT_CNT_W
) (
	input  wire logic                     clk,        // system clock
	input  wire logic                     sys_rst,    // sync reset
	input  wire logic                     pin,        // raw remote input
	input  wire remote_io_pkg::in_ctrl_e  ctrl,       // committed interpretation
	input  wire logic                     repeat_en,  // hold repeats steps
	input  wire logic                     clear,      // commit strobe
	output logic                          level,      // synchronised level
	output remote_io_pkg::in_event_s      ev          // decoded events
);

	logic             sync1_reg;
	logic             sync2_reg;
	logic             prev_reg;
	logic             flip_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic             rise;
	logic             fall;
	logic             lvl_on;
	logic             lvl_was;
	logic             fire;
	logic             cur_active;

	// ----------------------------------------------------------------
	// synchroniser and edge detect
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg  <= 1'b0;
		end
		else
		begin
			sync1_reg <= pin;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	assign level = sync2_reg;
	assign rise  = sync2_reg & ~prev_reg;
	assign fall  = ~sync2_reg & prev_reg;

	// ----------------------------------------------------------------
	// level modes and hold-repeat timer
	// ----------------------------------------------------------------
	assign lvl_on  = (ctrl == remote_io_pkg::CT_ACTIVE_HIGH) ? sync2_reg : ~sync2_reg;
	assign lvl_was = (ctrl == remote_io_pkg::CT_ACTIVE_HIGH) ? prev_reg : ~prev_reg;
	assign fire    = repeat_en && lvl_on && (cnt_reg == CNT_W'(REPEAT_CYCLES - 1));

	always_ff @(posedge clk)
	begin
		if (sys_rst || clear || !lvl_on || !lvl_was || fire)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_reg + CNT_W'(1);
	end

	// ----------------------------------------------------------------
	// toggle memory: falling toggle starts out active
	// ----------------------------------------------------------------
	assign cur_active = flip_reg ^ (ctrl == remote_io_pkg::CT_FALL_TOG);

	always_ff @(posedge clk)
	begin
		if (sys_rst || clear)
			flip_reg <= 1'b0;
		else if ((ctrl == remote_io_pkg::CT_FALL_TOG && fall) || (ctrl == remote_io_pkg::CT_RISE_TOG && rise))
			flip_reg <= ~flip_reg;
	end

	// ----------------------------------------------------------------
	// event decode
	// ----------------------------------------------------------------
	always_comb
	begin
		ev = '0;
		case (ctrl)
			remote_io_pkg::CT_FALL_ON:          ev.act = fall;
			remote_io_pkg::CT_RISE_ON:          ev.act = rise;
			remote_io_pkg::CT_FALL_OFF:         ev.deact = fall;
			remote_io_pkg::CT_RISE_OFF:         ev.deact = rise;
			remote_io_pkg::CT_FALL_TOG:
			begin
				ev.tog   = fall;
				ev.act   = fall & ~cur_active;
				ev.deact = fall & cur_active;
			end
			remote_io_pkg::CT_RISE_TOG:
			begin
				ev.tog   = rise;
				ev.act   = rise & ~cur_active;
				ev.deact = rise & cur_active;
			end
			remote_io_pkg::CT_RISE_ON_FALL_OFF:
			begin
				ev.act   = rise;
				ev.deact = fall;
			end
			remote_io_pkg::CT_FALL_ON_RISE_OFF:
			begin
				ev.act   = fall;
				ev.deact = rise;
			end
			remote_io_pkg::CT_ACTIVE_HIGH,
			remote_io_pkg::CT_ACTIVE_LOW:
			begin
				ev.act   = (lvl_on & ~lvl_was) | fire;
				ev.deact = ~lvl_on & lvl_was;
			end
			default:                            ev = '0;
		endcase
	end

endmodule : input_interpreter

`default_nettype wire

// ==== design/output_mapper.sv ====
/*
 * One remote output: picks a status or alarm condition and applies the
 * configured polarity. Purely combinational; the caller registers the pin.
 * Assumes status inputs are already synchronous to the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module output_mapper (
	input  wire remote_io_pkg::out_cfg_s  cfg,     // committed output config
	input  wire remote_io_pkg::status_s   status,  // transmitter conditions
	output logic                          pin      // level for the pin
);

	logic cond;

	always_comb
	begin
		case (cfg.src)
			remote_io_pkg::OS_NONE:      cond = 1'b0;
			remote_io_pkg::OS_RF_ON:     cond = status.rf_on;
			remote_io_pkg::OS_LOCAL:     cond = ~status.remote;
			remote_io_pkg::OS_EXCITER_A: cond = ~status.exciter_b;
			remote_io_pkg::OS_AUTO_CO:   cond = status.auto_co;
			remote_io_pkg::OS_PRESET:    cond = (status.preset == cfg.idx[remote_io_pkg::PRESET_W-1:0]);
			remote_io_pkg::OS_MOD_LOSS:  cond = status.mod_loss;
			remote_io_pkg::OS_ALARM:     cond = status.alarm[cfg.idx];
			default:                     cond = 1'b0;
		endcase
		// low_true: pin low while the condition holds
		pin = cfg.low_true ? ~cond : cond;
	end

endmodule : output_mapper

`default_nettype wire

// ==== design/remote_io_mapper.sv ====
/*
 * Remote parallel I/O mapper: 24 remote inputs mapped onto transmitter
 * control commands and 24 remote outputs driven from status and alarms.
 * Assumes a 50 MHz clock, synchronous active-high reset, and that the
 * operator interface stages configuration and then pulses cfg_commit.
 */
//
// Overview of operation
// - 24 inputs, own channel, control, level
// - inputs other than watchdog ignored unless control is remote
// - unassigned input never affects the transmitter
// - rf input acts like local rf on/off
// - reset input starts full system reset
// - power step 100W, repeat every half second
// - exciter input selects exciter A or B
// - toggle mode inverts auto changeover state
// - watchdog input reboots the operator interface
// - preset input makes its preset active
// - selectable activating edge or level per input
// - selectable deactivating edge or level per input
// - falling toggle starts on, rising starts off
// - paired edge modes activate and deactivate
// - power inputs level sensitive, selectable polarity
// - preset inputs level sensitive, selectable polarity
// - 24 outputs, own source, polarity, level
// - output drives chosen alarm or status condition
// - rf status output with selectable polarity
// - local/remote output with selectable polarity
// - active exciter output with selectable polarity
// - changeover, preset, modulation loss outputs polarity
`timescale 1ns/1ps
`default_nettype none

module remote_io_mapper #(
	parameter int REPEAT_CYCLES = remote_io_pkg::REPEAT_CYCLES
) (
	input  wire logic                                   clk,                // 50 MHz system clock
	input  wire logic                                   sys_rst,            // sync reset, active high
	input  wire logic [remote_io_pkg::N_IN-1:0]          remote_in,          // remote input pins
	input  wire logic                                   remote_mode,        // 1 remote, 0 local (front panel)
	input  wire logic                                   rf_on_state,        // rf presently on
	input  wire logic                                   exciter_b_state,    // exciter b presently active
	input  wire logic                                   auto_co_state,      // auto changeover enabled
	input  wire logic [remote_io_pkg::PRESET_W-1:0]      active_preset,      // active preset number
	input  wire logic                                   mod_loss,           // modulation loss condition
	input  wire logic [remote_io_pkg::ALARM_W-1:0]       alarm_in,           // general alarm conditions
	input  wire logic                                   in_cfg_wr,          // stage one input config
	input  wire logic [remote_io_pkg::SEL_W-1:0]         in_cfg_sel,         // input number to stage
	input  wire remote_io_pkg::in_cfg_s                 in_cfg_data,        // staged input config
	input  wire logic                                   out_cfg_wr,         // stage one output config
	input  wire logic [remote_io_pkg::SEL_W-1:0]         out_cfg_sel,        // output number to stage
	input  wire remote_io_pkg::out_cfg_s                out_cfg_data,       // staged output config
	input  wire logic                                   cfg_commit,         // apply all staged config
	output logic [remote_io_pkg::N_IN-1:0]               remote_in_level,    // synchronised input levels
	output logic [remote_io_pkg::N_OUT-1:0]              remote_out,         // remote output pins
	output logic                                        rf_on_cmd,          // pulse: rf on request
	output logic                                        rf_off_cmd,         // pulse: rf off request
	output logic                                        reset_cmd,          // pulse: system reset
	output logic                                        watchdog_cmd,       // pulse: reboot operator_interface
	output logic                                        power_step_cmd,     // pulse: apply power step
	output logic signed [remote_io_pkg::STEP_W-1:0]      power_step_w,       // step size in watts, signed
	output logic                                        exciter_a_cmd,      // pulse: select exciter a
	output logic                                        exciter_b_cmd,      // pulse: select exciter b
	output logic                                        auto_co_on_cmd,     // pulse: enable auto changeover
	output logic                                        auto_co_off_cmd,    // pulse: disable auto changeover
	output logic                                        auto_co_toggle_cmd, // pulse: invert auto changeover
	output logic                                        preset_sel_cmd,     // pulse: make preset active
	output logic [remote_io_pkg::PRESET_W-1:0]           preset_sel_idx      // preset for preset_sel_cmd
);

	localparam int N_IN  = remote_io_pkg::N_IN;
	localparam int N_OUT = remote_io_pkg::N_OUT;
	localparam int PW    = remote_io_pkg::PRESET_W;

	// ----------------------------------------------------------------
	// configuration storage
	// ----------------------------------------------------------------
	remote_io_pkg::in_cfg_s   in_stage_reg [N_IN];
	remote_io_pkg::in_cfg_s   in_cfg_reg   [N_IN];
	remote_io_pkg::out_cfg_s  out_stage_reg[N_OUT];
	remote_io_pkg::out_cfg_s  out_cfg_reg  [N_OUT];
	logic                     clear_reg;

	// ----------------------------------------------------------------
	// per-input events and combined requests
	// ----------------------------------------------------------------
	remote_io_pkg::in_event_s ev    [N_IN];
	remote_io_pkg::status_s   status;
	logic [N_OUT-1:0]         out_level;
	logic                     rf_on_next;
	logic                     rf_off_next;
	logic                     reset_next;
	logic                     watchdog_next;
	logic                     inc_next;
	logic                     dec_next;
	logic                     exc_a_next;
	logic                     exc_b_next;
	logic                     co_on_next;
	logic                     co_off_next;
	logic                     co_tog_next;
	logic                     preset_next;
	logic [PW-1:0]            preset_idx_next;

	// in range and within the 24 inputs or outputs
	function automatic logic sel_ok(input logic [remote_io_pkg::SEL_W-1:0] sel, input int n);
		sel_ok = (int'(sel) < n);
	endfunction : sel_ok

	// watchdog stays usable in local control so a hung interface can be recovered
	function automatic logic gate_ok(input remote_io_pkg::in_chan_e chan, input logic remote);
		gate_ok = remote || (chan == remote_io_pkg::CH_WATCHDOG);
	endfunction : gate_ok

	// ----------------------------------------------------------------
	// staging: writes land in the shadow copy only
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < N_IN; i++)
				in_stage_reg[i] <= remote_io_pkg::IN_CFG_RST;
		end
		else if (in_cfg_wr && sel_ok(in_cfg_sel, N_IN))
			in_stage_reg[in_cfg_sel] <= in_cfg_data;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < N_OUT; i++)
				out_stage_reg[i] <= remote_io_pkg::OUT_CFG_RST;
		end
		else if (out_cfg_wr && sel_ok(out_cfg_sel, N_OUT))
			out_stage_reg[out_cfg_sel] <= out_cfg_data;
	end

	// ----------------------------------------------------------------
	// commit: all settings switch over in one cycle
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < N_IN; i++)
				in_cfg_reg[i] <= remote_io_pkg::IN_CFG_RST;
			for (int i = 0; i < N_OUT; i++)
				out_cfg_reg[i] <= remote_io_pkg::OUT_CFG_RST;
		end
		else if (cfg_commit)
		begin
			for (int i = 0; i < N_IN; i++)
				in_cfg_reg[i] <= in_stage_reg[i];
			for (int i = 0; i < N_OUT; i++)
				out_cfg_reg[i] <= out_stage_reg[i];
		end
	end

	// toggle memories and repeat timers restart under the new settings
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			clear_reg <= 1'b0;
		else
			clear_reg <= cfg_commit;
	end

	// ----------------------------------------------------------------
	// input channels
	// ----------------------------------------------------------------
	for (genvar g = 0; g < N_IN; g++)
	begin : g_in
		input_interpreter #(
			.REPEAT_CYCLES (REPEAT_CYCLES),
			.CNT_W         (remote_io_pkg::REPEAT_CNT_W)
		) u_in (
			.clk       (clk),
			.sys_rst   (sys_rst),
			.pin       (remote_in[g]),
			.ctrl      (in_cfg_reg[g].ctrl),
			.repeat_en (in_cfg_reg[g].chan == remote_io_pkg::CH_PWR_INC
			            || in_cfg_reg[g].chan == remote_io_pkg::CH_PWR_DEC),
			.clear     (clear_reg),
			.level     (remote_in_level[g]),
			.ev        (ev[g])
		);
	end

	// ----------------------------------------------------------------
	// merge events by channel; lowest numbered preset input wins
	// ----------------------------------------------------------------
	always_comb
	begin
		rf_on_next      = 1'b0;
		rf_off_next     = 1'b0;
		reset_next      = 1'b0;
		watchdog_next   = 1'b0;
		inc_next        = 1'b0;
		dec_next        = 1'b0;
		exc_a_next      = 1'b0;
		exc_b_next      = 1'b0;
		co_on_next      = 1'b0;
		co_off_next     = 1'b0;
		co_tog_next     = 1'b0;
		preset_next     = 1'b0;
		preset_idx_next = '0;
		for (int i = N_IN - 1; i >= 0; i--)
		begin
			if (gate_ok(in_cfg_reg[i].chan, remote_mode))
			begin
				case (in_cfg_reg[i].chan)
					remote_io_pkg::CH_NONE:     ;
					remote_io_pkg::CH_RF:
					begin
						rf_on_next  = rf_on_next | ev[i].act;
						rf_off_next = rf_off_next | ev[i].deact;
					end
					remote_io_pkg::CH_RESET:    reset_next = reset_next | ev[i].act;
					remote_io_pkg::CH_PWR_INC:  inc_next = inc_next | ev[i].act;
					remote_io_pkg::CH_PWR_DEC:  dec_next = dec_next | ev[i].act;
					remote_io_pkg::CH_EXCITER:
					begin
						exc_b_next = exc_b_next | ev[i].act;
						exc_a_next = exc_a_next | ev[i].deact;
					end
					remote_io_pkg::CH_AUTO_CO:
					begin
						co_tog_next = co_tog_next | ev[i].tog;
						co_on_next  = co_on_next | (ev[i].act & ~ev[i].tog);
						co_off_next = co_off_next | (ev[i].deact & ~ev[i].tog);
					end
					remote_io_pkg::CH_WATCHDOG: watchdog_next = watchdog_next | ev[i].act;
					remote_io_pkg::CH_PRESET:
					begin
						if (ev[i].act)
						begin
							preset_next     = 1'b1;
							preset_idx_next = in_cfg_reg[i].preset;
						end
					end
					default:                    ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// command pulses
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rf_on_cmd    <= 1'b0;
			rf_off_cmd   <= 1'b0;
			reset_cmd    <= 1'b0;
			watchdog_cmd <= 1'b0;
		end
		else
		begin
			// off wins a same-cycle conflict as the safer request
			rf_on_cmd    <= rf_on_next & ~rf_off_next;
			rf_off_cmd   <= rf_off_next;
			reset_cmd    <= reset_next;
			watchdog_cmd <= watchdog_next;
		end
	end

	// opposite power steps in one cycle cancel out
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			power_step_cmd <= 1'b0;
			power_step_w   <= '0;
		end
		else
		begin
			power_step_cmd <= inc_next ^ dec_next;
			if (inc_next && !dec_next)
				power_step_w <= remote_io_pkg::STEP_W'(remote_io_pkg::POWER_STEP_WATT);
			else if (dec_next && !inc_next)
				power_step_w <= -remote_io_pkg::STEP_W'(remote_io_pkg::POWER_STEP_WATT);
		end
	end

	// conflicting exciter requests in one cycle are both dropped
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			exciter_a_cmd <= 1'b0;
			exciter_b_cmd <= 1'b0;
		end
		else
		begin
			exciter_a_cmd <= exc_a_next & ~exc_b_next;
			exciter_b_cmd <= exc_b_next & ~exc_a_next;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			auto_co_on_cmd     <= 1'b0;
			auto_co_off_cmd    <= 1'b0;
			auto_co_toggle_cmd <= 1'b0;
		end
		else
		begin
			auto_co_toggle_cmd <= co_tog_next;
			auto_co_on_cmd     <= co_on_next & ~co_off_next & ~co_tog_next;
			auto_co_off_cmd    <= co_off_next & ~co_tog_next;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			preset_sel_cmd <= 1'b0;
			preset_sel_idx <= '0;
		end
		else
		begin
			preset_sel_cmd <= preset_next;
			if (preset_next)
				preset_sel_idx <= preset_idx_next;
		end
	end

	// ----------------------------------------------------------------
	// output channels
	// ----------------------------------------------------------------
	assign status = '{rf_on: rf_on_state, remote: remote_mode, exciter_b: exciter_b_state,
	                  auto_co: auto_co_state, mod_loss: mod_loss, preset: active_preset,
	                  alarm: alarm_in};

	for (genvar g = 0; g < N_OUT; g++)
	begin : g_out
		output_mapper u_out (
			.cfg    (out_cfg_reg[g]),
			.status (status),
			.pin    (out_level[g])
		);
	end

	// the pin register doubles as the reported output level
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			remote_out <= '0;
		else
			remote_out <= out_level;
	end

endmodule : remote_io_mapper

`default_nettype wire

// ==== tb/remote_io_mapper_assertions.sv ====
/* checker for remote_io_mapper command pulses and pin sync
   bound from the bench top; sees top ports only */
`timescale 1ns/1ps
`default_nettype none
module remote_io_mapper_assertions (
	input wire logic               clk,             // clock
	input wire logic               sys_rst,         // reset
	input wire logic [23:0]        remote_in,       // pins
	input wire logic [23:0]        remote_in_level, // synced
	input wire logic               remote_mode,     // remote
	input wire logic               rf_on_cmd,       // on
	input wire logic               rf_off_cmd,      // off
	input wire logic               reset_cmd,       // reset
	input wire logic               power_step_cmd,  // step
	input wire logic signed [15:0] power_step_w,    // watts
	input wire logic               exciter_a_cmd,   // a
	input wire logic               exciter_b_cmd    // b
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// gating may sit at either sync stage, so four local samples
	sequence s_local; !remote_mode [*4]; endsequence
	property p_rf; !(rf_on_cmd && rf_off_cmd); endproperty
	a_rf: assert property (p_rf) else $error("rf on and off together");
	property p_on1; rf_on_cmd |=> !rf_on_cmd; endproperty
	a_on1: assert property (p_on1) else $error("rf on held");
	property p_rst1; reset_cmd |=> !reset_cmd; endproperty
	a_rst1: assert property (p_rst1) else $error("reset held");
	property p_gate; s_local |-> !(rf_on_cmd || reset_cmd || power_step_cmd); endproperty
	a_gate: assert property (p_gate) else $error("command in local");
	property p_step; power_step_cmd |-> power_step_w == 16'sh0064 || power_step_w == -16'sh0064; endproperty
	a_step: assert property (p_step) else $error("bad step size");
	property p_hold; !power_step_cmd |-> $stable(power_step_w); endproperty
	a_hold: assert property (p_hold) else $error("step size moved");
	property p_exc; !(exciter_a_cmd && exciter_b_cmd); endproperty
	a_exc: assert property (p_exc) else $error("both exciters");
	property p_sync; !$past(sys_rst, 2) && !$past(sys_rst) |-> remote_in_level == $past(remote_in, 2); endproperty
	a_sync: assert property (p_sync) else $error("level not two flops behind");
endmodule : remote_io_mapper_assertions
`default_nettype wire

// ==== tb/remote_ctrl_unit.sv ====
/* remote control unit model: owns the 24 contacts
   assumes the bench calls set_pin from its main sequence */
`timescale 1ns/1ps
`default_nettype none
module remote_ctrl_unit (
	input  wire logic        clk,  // clock
	output var  logic [23:0] pins  // contacts
);
	initial pins = 24'hff_ffff; // open contacts pulled high
	task automatic set_pin(input int i, input logic v);
		@(posedge clk) pins[i] <= v;
	endtask : set_pin
endmodule : remote_ctrl_unit
`default_nettype wire

// ==== tb/remote_io_mapper_tb.sv ====
/* bench for remote_io_mapper: unit model drives the pins, status is random
   assumes the repeat timer shortened to 20 cycles */
`timescale 1ns/1ps
`default_nettype none
module remote_io_mapper_tb;
	logic clk = 0, sys_rst = 1, remote_mode = 1, in_cfg_wr = 0, out_cfg_wr = 0, cfg_commit = 0;
	logic [4:0] sel = 0;
	wire [10:0] cmd;
	logic [7:0] tab [9] = '{8'h10, 8'h13, 8'h70, 8'h01, 8'h39, 8'h64, 8'h56, 8'h89, 8'h20};
	logic [23:0] remote_in, remote_in_level, remote_out;
	logic signed [15:0] power_step_w;
	logic [2:0] preset_sel_idx;
	remote_io_pkg::in_cfg_s in_cfg_data = '0;
	remote_io_pkg::out_cfg_s out_cfg_data = '0, oq [8];
	remote_io_pkg::status_s st = '0;
	int cnt [11], bad_count = 0, compares = 0, cyc = 0, seed = 82244;
	remote_ctrl_unit u_unit (.clk, .pins(remote_in));
	remote_io_mapper #(.REPEAT_CYCLES(20)) u_dut (.clk, .sys_rst, .remote_in, .remote_mode, .rf_on_state(st.rf_on),
		.exciter_b_state(st.exciter_b), .auto_co_state(st.auto_co), .active_preset(st.preset),
		.mod_loss(st.mod_loss), .alarm_in(st.alarm), .in_cfg_wr, .in_cfg_sel(sel), .in_cfg_data, .out_cfg_wr,
		.out_cfg_sel(sel), .out_cfg_data, .cfg_commit, .remote_in_level, .remote_out, .rf_on_cmd(cmd[0]),
		.rf_off_cmd(cmd[1]), .reset_cmd(cmd[2]), .watchdog_cmd(cmd[3]), .power_step_cmd(cmd[4]), .power_step_w,
		.exciter_a_cmd(cmd[5]), .exciter_b_cmd(cmd[6]), .auto_co_on_cmd(cmd[7]), .auto_co_off_cmd(cmd[8]),
		.auto_co_toggle_cmd(cmd[9]), .preset_sel_cmd(cmd[10]), .preset_sel_idx);
	always #10 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		foreach (cnt[i]) cnt[i] += cmd[i];
		if (cyc == 3000) // sequence needs about 375 cycles
		begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("bad_count=%0d compares=%0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	task automatic stage(input int i, input logic [10:0] d, input logic o, c);
		@(posedge clk) {in_cfg_wr, out_cfg_wr, sel, in_cfg_data, out_cfg_data} <= {!o, o, 5'(i), d, d[7:0]};
		@(posedge clk) {in_cfg_wr, out_cfg_wr, cfg_commit} <= {2'b00, c};
		@(posedge clk) cfg_commit <= 0;
	endtask : stage
	// off-edge snapshots keep the counts clear of the counting process
	task automatic go(input int i, input logic v, input int n, input int k, input int e);
		int c0 [11], s;
		#1 c0 = cnt;
		u_unit.set_pin(i, v);
		repeat (n) @(posedge clk);
		#1 s = 0;
		foreach (cnt[j]) s += cnt[j] - c0[j];
		check(cnt[k] - c0[k], e);
		check(s, e);
	endtask : go
	function automatic logic exp_out(remote_io_pkg::out_cfg_s c);
		logic [7:0] v = {st.alarm[c.idx], st.mod_loss, st.preset == c.idx[2:0], st.auto_co, !st.exciter_b,
			!remote_mode, st.rf_on, 1'b0};
		return v[c.src] ^ c.low_true;
	endfunction : exp_out
	initial
	begin
		repeat (20) @(posedge clk);
		sys_rst <= 0;
		stage(0, {tab[0], 3'h5}, 0, 0);
		go(0, 0, 6, 0, 0);
		go(0, 1, 4, 0, 0);
		for (int k = 0; k < 9; k++) stage(k, {tab[k], 3'h5}, 0, 1);
		for (int k = 0; k < 8; k++)
		begin
			oq[k] = {k[2:0], 4'($random(seed)), k[0]};
			stage(k, 11'(oq[k]), 1, 1);
		end
		go(0, 0, 6, 0, 1);
		go(0, 1, 4, 0, 0);
		go(1, 0, 4, 1, 0);
		go(1, 1, 6, 1, 1);
		go(8, 0, 6, 2, 1);
		go(5, 0, 6, 9, 1);
		go(5, 1, 4, 9, 0);
		go(5, 0, 6, 9, 1);
		go(6, 0, 6, 5, 1);
		go(6, 1, 6, 6, 1);
		go(7, 0, 6, 10, 1);
		check(preset_sel_idx, 5);
		go(4, 0, 50, 4, 3);
		check(power_step_w, 100);
		go(4, 1, 25, 4, 0);
		stage(4, {8'h49, 3'h5}, 0, 1);
		go(4, 0, 6, 4, 1);
		check(power_step_w, -100);
		go(4, 1, 4, 4, 0);
		repeat (6) go(3, $random(seed), 4, 0, 0);
		@(posedge clk) remote_mode <= 0;
		go(0, 0, 6, 0, 0);
		go(2, 0, 6, 3, 1);
		repeat (20)
		begin
			@(posedge clk) st <= 24'($random(seed));
			remote_mode <= 1'($random(seed));
			repeat (3) @(posedge clk);
			#1 foreach (oq[k]) check(remote_out[k], exp_out(oq[k]));
		end
		check(remote_out[23:8], 0);
		check(remote_in_level, remote_in);
		print_verdict();
	end
endmodule : remote_io_mapper_tb
bind remote_io_mapper remote_io_mapper_assertions u_chk (.clk, .sys_rst, .remote_in, .remote_in_level,
	.remote_mode, .rf_on_cmd, .rf_off_cmd, .reset_cmd, .power_step_cmd, .power_step_w, .exciter_a_cmd, .exciter_b_cmd);
`default_nettype wire
